// ==== include/lmf_pkg.sv ====
package lmf_pkg;
    typedef enum logic [3:0] {
        M_BOOT, M_STORE, M_UPGRADE, M_CFG_READ, M_DFLT, M_FLASH_R, M_FLASH_Y,
        M_AUTOBAUD, M_LOG, M_ERR
    } lmf_mode_t;
    typedef enum logic [2:0] {F_IDLE, F_ID, F_DATA, F_CRC_H, F_CRC_L, F_FLAG_E} lmf_frm_t;
    typedef struct packed {
        lmf_mode_t mode;
        lmf_frm_t frm;
        logic store;
        logic fw_accept;
        logic img_armed;
        logic serial_en;
        logic cfg_read;
        logic cfg_load;
        logic dflt_wr;
        logic g;
        logic y;
        logic r;
        logic [23:0] led_cnt;
        logic [2:0] halves;
        logic [23:0] act_cnt;
        logic [23:0] wr_cnt;
        logic [15:0] crc;
        logic [7:0] pend;
        logic have;
        logic esc;
        logic last;
        logic pl_ready;
        logic busy;
        logic [9:0] sh;
        logic [3:0] bits;
        logic [8:0] baud;
        logic tx;
    } lmf_state_t;
endpackage

// ==== include/lmf_regs.svh ====
// Behaviour
// RQ1 - Booting without USB host selects logging; storage access over USB denied.
// RQ2 - Host attached after logging starts enables the serial interface.
// RQ3 - Logging start reads card configuration; a valid one is loaded.
// RQ4 - Without valid configuration a default is written, then loaded.
// RQ5 - During boot green is steady, yellow and red dark.
// RQ6 - Default written: red flashes exactly three times, green on.
// RQ7 - Valid configuration loaded: yellow flashes exactly three times, green on.
// RQ8 - Auto rate detection holds yellow and green on until rate found.
// RQ9 - Logging: yellow follows bus traffic, red follows card writes, green on.
// RQ10 - Card fault: yellow and red steady, green off.
// RQ11 - Button held at USB power-up: upgrade mode, red only, images accepted.
// RQ12 - A new image runs only after a full power cycle.
// RQ13 - Serial link is 115200 bit/s, 8 data bits, 1 stop, no parity.
// RQ14 - Frame is flag 7E, payload, CRC high byte first, flag 7E.
// RQ15 - Payload or CRC bytes equal to the flag are escaped with 7D.
// RQ16 - Host splits frames on flags and scans for the control byte.
// RQ17 - Escaped byte has bit 5 inverted; receiver drops 7D and restores.
// RQ18 - CRC is 16-bit, polynomial 8005, over the unstuffed payload.
// RQ19 - Payload starts with id byte: 1 received, 2 transmitted message.
// RQ20 - Record fields go most significant byte first; id bit 29 marks extended.
// RQ21 - Bytes equal to the control byte are escaped as well.
`ifndef LMF_REGS_SVH
`define LMF_REGS_SVH
`define LMF_FLAG 8'h7E
`define LMF_CTRL 8'h7D
`define LMF_FLIP 8'h20
`define LMF_POLY 16'h8005
`define LMF_ID_RX 8'h01
`define LMF_ID_TX 8'h02
`define LMF_CLK_HZ 50000000
`define LMF_BAUD 115200
`define LMF_BAUD_CYC (`LMF_CLK_HZ / `LMF_BAUD)
`define LMF_UART_BITS 4'hA
`define LMF_FLASH_MS 250
`define LMF_ACT_MS 20
`define LMF_LAST_HALF 3'h5
`endif

// ==== rtl/lmf_framer_top.sv ====
`timescale 1ns/10ps
`include "lmf_regs.svh"
module lmf_framer_top #(
    parameter logic [23:0] FLASH_CYC = 24'(`LMF_FLASH_MS * (`LMF_CLK_HZ / 1000)),
    parameter logic [23:0] ACT_CYC = 24'(`LMF_ACT_MS * (`LMF_CLK_HZ / 1000))
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic usb_host_in,
    input wire logic upgrade_btn_in,
    input wire logic cfg_done_in,
    input wire logic cfg_valid_in,
    input wire logic dflt_written_in,
    input wire logic autobaud_in,
    input wire logic rate_found_in,
    input wire logic bus_act_in,
    input wire logic mem_wr_in,
    input wire logic mem_err_in,
    input wire logic upload_done_in,
    input wire logic pl_valid_in,
    input wire logic [7:0] pl_data_in,
    input wire logic pl_last_in,
    input wire logic msg_tx_in,
    output logic pl_ready_out,
    output logic usb_storage_mode_out,
    output logic fw_accept_out,
    output logic img_armed_out,
    output logic serial_en_out,
    output logic cfg_read_out,
    output logic cfg_load_out,
    output logic dflt_write_out,
    output logic led_green_out,
    output logic led_yellow_out,
    output logic led_red_out,
    output logic tx_out
);
    localparam logic [8:0] BAUD_LAST = 9'(`LMF_BAUD_CYC - 1);
    lmf_pkg::lmf_state_t s, n;
    logic in_log;
    logic snd;
    logic adv;
    logic [7:0] b;
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            x = x[15] ? ((x << 1) ^ `LMF_POLY) : (x << 1);
        end
        return x;
    endfunction
    // --------------------------------------------------------------
    // Mode sequencing, indicators and framer
    // --------------------------------------------------------------
    always_comb begin
        n = s;
        n.cfg_load = 1'b0;
        n.dflt_wr = 1'b0;
        snd = 1'b0;
        adv = 1'b0;
        b = 8'h00;
        in_log = (s.mode != lmf_pkg::M_BOOT) && (s.mode != lmf_pkg::M_STORE) &&
                 (s.mode != lmf_pkg::M_UPGRADE) && (s.mode != lmf_pkg::M_ERR);
        case (s.mode)
            lmf_pkg::M_BOOT: begin
                n.mode = usb_host_in ? lmf_pkg::M_STORE : lmf_pkg::M_CFG_READ; // RQ1
                if (usb_host_in && upgrade_btn_in) begin
                    n.mode = lmf_pkg::M_UPGRADE; // RQ11
                end
            end
            lmf_pkg::M_UPGRADE: begin
                // Image only armed; it runs after the next power cycle
                n.img_armed = s.img_armed || upload_done_in; // RQ12
            end
            lmf_pkg::M_CFG_READ: begin
                n.led_cnt = FLASH_CYC;
                n.halves = 3'h0;
                if (cfg_done_in && cfg_valid_in) begin
                    n.cfg_load = 1'b1; // RQ3
                    n.mode = lmf_pkg::M_FLASH_Y;
                end else if (cfg_done_in) begin
                    n.dflt_wr = 1'b1; // RQ4
                    n.mode = lmf_pkg::M_DFLT;
                end
            end
            lmf_pkg::M_DFLT: begin
                if (dflt_written_in) begin
                    n.cfg_load = 1'b1; // RQ4
                    n.mode = lmf_pkg::M_FLASH_R;
                end
            end
            lmf_pkg::M_FLASH_R, lmf_pkg::M_FLASH_Y: begin
                if (s.led_cnt == 24'h000000) begin
                    n.led_cnt = FLASH_CYC;
                    n.halves = s.halves + 3'h1;
                    if (s.halves == `LMF_LAST_HALF) begin
                        n.mode = autobaud_in ? lmf_pkg::M_AUTOBAUD : lmf_pkg::M_LOG;
                    end
                end else begin
                    n.led_cnt = s.led_cnt - 24'h000001;
                end
            end
            lmf_pkg::M_AUTOBAUD: begin
                if (rate_found_in) begin
                    n.mode = lmf_pkg::M_LOG; // RQ8
                end
            end
            lmf_pkg::M_STORE, lmf_pkg::M_LOG, lmf_pkg::M_ERR: begin
            end
            default: begin
                n.mode = lmf_pkg::M_BOOT;
            end
        endcase
        if (in_log && mem_err_in) begin
            n.mode = lmf_pkg::M_ERR; // RQ10
        end
        // Activity stretchers so short events stay visible
        n.act_cnt = bus_act_in ? ACT_CYC :
                    (s.act_cnt != 24'h000000) ? s.act_cnt - 24'h000001 : 24'h000000;
        n.wr_cnt = mem_wr_in ? ACT_CYC :
                   (s.wr_cnt != 24'h000000) ? s.wr_cnt - 24'h000001 : 24'h000000;
        n.store = (n.mode == lmf_pkg::M_STORE); // RQ1
        n.fw_accept = (n.mode == lmf_pkg::M_UPGRADE) && !n.img_armed; // RQ11
        n.cfg_read = (n.mode == lmf_pkg::M_CFG_READ); // RQ3
        n.serial_en = in_log && (n.mode != lmf_pkg::M_ERR) && usb_host_in; // RQ2
        // Byte source: load the next unstuffed byte when empty
        if (!s.have) begin
            case (s.frm)
                lmf_pkg::F_DATA: begin
                    if (s.pl_ready && pl_valid_in) begin
                        n.pend = pl_data_in; // RQ20
                        n.last = pl_last_in;
                        n.crc = crc_upd(s.crc, pl_data_in); // RQ18
                        n.have = 1'b1;
                    end
                end
                lmf_pkg::F_CRC_H, lmf_pkg::F_CRC_L: begin
                    n.pend = (s.frm == lmf_pkg::F_CRC_H) ? s.crc[15:8] : s.crc[7:0]; // RQ14
                    n.have = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // Byte sender: flags raw, everything else through the stuffer
        if (!s.busy) begin
            case (s.frm)
                lmf_pkg::F_IDLE: begin
                    if (s.serial_en && s.mode == lmf_pkg::M_LOG && pl_valid_in) begin
                        snd = 1'b1;
                        b = `LMF_FLAG; // RQ14
                        n.pend = msg_tx_in ? `LMF_ID_TX : `LMF_ID_RX; // RQ19
                        n.crc = crc_upd(16'h0000, n.pend); // RQ18
                        n.have = 1'b1;
                        n.frm = lmf_pkg::F_ID;
                    end
                end
                lmf_pkg::F_FLAG_E: begin
                    snd = 1'b1;
                    b = `LMF_FLAG; // RQ14
                    n.frm = lmf_pkg::F_IDLE;
                end
                default: begin
                    if (s.have && s.esc) begin
                        snd = 1'b1;
                        b = s.pend ^ `LMF_FLIP; // RQ17
                        n.esc = 1'b0;
                        adv = 1'b1;
                    end else if (s.have && (s.pend == `LMF_FLAG || s.pend == `LMF_CTRL)) begin
                        snd = 1'b1;
                        b = `LMF_CTRL; // RQ15 RQ21
                        n.esc = 1'b1;
                    end else if (s.have) begin
                        snd = 1'b1;
                        b = s.pend;
                        adv = 1'b1;
                    end
                end
            endcase
        end
        if (adv) begin
            n.have = 1'b0;
            case (s.frm)
                lmf_pkg::F_ID: n.frm = lmf_pkg::F_DATA;
                lmf_pkg::F_DATA: n.frm = s.last ? lmf_pkg::F_CRC_H : lmf_pkg::F_DATA;
                lmf_pkg::F_CRC_H: n.frm = lmf_pkg::F_CRC_L;
                default: n.frm = lmf_pkg::F_FLAG_E;
            endcase
        end
        n.pl_ready = (n.frm == lmf_pkg::F_DATA) && !n.have;
        // Start bit, 8 data bits LSB first, one stop bit, no parity
        if (snd) begin
            n.busy = 1'b1;
            n.sh = {1'b1, b, 1'b0}; // RQ13
            n.bits = `LMF_UART_BITS;
            n.baud = BAUD_LAST;
        end else if (s.busy && s.baud == 9'h000) begin
            n.baud = BAUD_LAST;
            n.sh = {1'b1, s.sh[9:1]};
            n.bits = s.bits - 4'h1;
            n.busy = (s.bits != 4'h1);
        end else if (s.busy) begin
            n.baud = s.baud - 9'h001;
        end
        n.tx = n.busy ? n.sh[0] : 1'b1;
        case (n.mode)
            lmf_pkg::M_FLASH_R: {n.g, n.y, n.r} = {1'b1, 1'b0, !n.halves[0]}; // RQ6
            lmf_pkg::M_FLASH_Y: {n.g, n.y, n.r} = {1'b1, !n.halves[0], 1'b0}; // RQ7
            lmf_pkg::M_AUTOBAUD: {n.g, n.y, n.r} = 3'b110; // RQ8
            lmf_pkg::M_LOG: {n.g, n.y, n.r} = {1'b1, |n.act_cnt, |n.wr_cnt}; // RQ9
            lmf_pkg::M_ERR: {n.g, n.y, n.r} = 3'b011; // RQ10
            lmf_pkg::M_UPGRADE: {n.g, n.y, n.r} = 3'b001; // RQ11
            default: {n.g, n.y, n.r} = 3'b100; // RQ5
        endcase
    end
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s <= '0;
            s.tx <= 1'b1;
        end else begin
            s <= n;
        end
    end
    assign pl_ready_out = s.pl_ready;
    assign usb_storage_mode_out = s.store;
    assign fw_accept_out = s.fw_accept;
    assign img_armed_out = s.img_armed;
    assign serial_en_out = s.serial_en;
    assign cfg_read_out = s.cfg_read;
    assign cfg_load_out = s.cfg_load;
    assign dflt_write_out = s.dflt_wr;
    assign led_green_out = s.g;
    assign led_yellow_out = s.y;
    assign led_red_out = s.r;
    assign tx_out = s.tx;
    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    sequence seq_err_cause;
        in_log && mem_err_in;
    endsequence
    sequence seq_err_leds;
        !led_green_out && led_yellow_out && led_red_out;
    endsequence
    property p_no_store_log;
        (s.mode == lmf_pkg::M_BOOT && !usb_host_in) |=> ##1 !usb_storage_mode_out;
    endproperty
    a_no_store_log: assert property (p_no_store_log) else $error("storage in logging"); // RQ1
    property p_serial_on;
        (in_log && s.mode != lmf_pkg::M_ERR && usb_host_in && !mem_err_in) |=> serial_en_out;
    endproperty
    a_serial_on: assert property (p_serial_on) else $error("serial not enabled"); // RQ2
    property p_cfg_load;
        (s.mode == lmf_pkg::M_CFG_READ && cfg_done_in && cfg_valid_in && !mem_err_in)
            |=> cfg_load_out ##1 !cfg_load_out;
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config load pulse"); // RQ3
    property p_dflt;
        (s.mode == lmf_pkg::M_CFG_READ && cfg_done_in && !cfg_valid_in && !mem_err_in)
            |=> dflt_write_out && !cfg_load_out;
    endproperty
    a_dflt: assert property (p_dflt) else $error("default not written"); // RQ4
    property p_boot_led;
        (s.mode == lmf_pkg::M_CFG_READ) |-> led_green_out && !led_yellow_out && !led_red_out;
    endproperty
    a_boot_led: assert property (p_boot_led) else $error("boot leds"); // RQ5
    property p_flash_r;
        (s.mode == lmf_pkg::M_FLASH_R) |-> led_green_out && !led_yellow_out;
    endproperty
    a_flash_r: assert property (p_flash_r) else $error("red flash leds"); // RQ6
    property p_flash_y;
        (s.mode == lmf_pkg::M_FLASH_Y) |-> led_green_out && !led_red_out;
    endproperty
    a_flash_y: assert property (p_flash_y) else $error("yellow flash leds"); // RQ7
    property p_autobaud;
        (s.mode == lmf_pkg::M_AUTOBAUD) |-> led_green_out && led_yellow_out && !led_red_out;
    endproperty
    a_autobaud: assert property (p_autobaud) else $error("autobaud leds"); // RQ8
    property p_mem_err;
        seq_err_cause |=> seq_err_leds;
    endproperty
    a_mem_err: assert property (p_mem_err) else $error("memory error leds"); // RQ10
    property p_upgrade;
        (s.mode == lmf_pkg::M_UPGRADE) |-> led_red_out && !led_green_out && !led_yellow_out;
    endproperty
    a_upgrade: assert property (p_upgrade) else $error("upgrade leds"); // RQ11
    property p_start_bit;
        snd |=> !tx_out && s.bits == `LMF_UART_BITS;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit"); // RQ13
    property p_open_flag;
        (snd && s.frm == lmf_pkg::F_IDLE) |-> b == `LMF_FLAG;
    endproperty
    a_open_flag: assert property (p_open_flag) else $error("frame not opened by flag"); // RQ14
    property p_no_raw_flag;
        (snd && b == `LMF_FLAG) |-> (s.frm == lmf_pkg::F_IDLE || s.frm == lmf_pkg::F_FLAG_E);
    endproperty
    a_no_raw_flag: assert property (p_no_raw_flag) else $error("flag inside frame"); // RQ15
endmodule

// ==== tb/lmf_host_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Host side: UART receiver and frame decoder
// ----------------------------------------
module lmf_host_model #(
    parameter int BIT_CYC = 434
) (
    input wire logic core_clk_in,
    input wire logic rx_in,
    output int frames_out,
    output int len_out,
    output logic good_out,
    output logic [7:0] data_out [8]
);
    logic [7:0] rx_buf [16];
    logic [7:0] b;
    logic [15:0] crc;
    logic esc;
    int n;

    initial begin
        frames_out = 0;
        len_out = 0;
        good_out = 1'b0;
        n = -1;
        esc = 1'b0;
    end

    always begin
        @(negedge rx_in);
        repeat (BIT_CYC / 2) @(posedge core_clk_in);
        if (rx_in === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge core_clk_in);
                b[i] = rx_in;
            end
            repeat (BIT_CYC) @(posedge core_clk_in);
            if (rx_in !== 1'b1) begin
                n = -1;
            end else if (b == 8'h7E) begin
                // Flag closes any open frame, then opens the next one
                if (n >= 3) begin
                    crc = 16'h0000;
                    for (int k = 0; k < n - 2; k++) begin
                        crc = crc ^ {rx_buf[k], 8'h00};
                        for (int j = 0; j < 8; j++) begin
                            crc = crc[15] ? ((crc << 1) ^ 16'h8005) : (crc << 1);
                        end
                    end
                    good_out = (crc === {rx_buf[n - 2], rx_buf[n - 1]});
                    len_out = n - 2;
                    for (int k = 0; k < 8; k++) begin
                        data_out[k] = rx_buf[k];
                    end
                    frames_out++;
                end
                n = 0;
                esc = 1'b0;
            end else if (n >= 0 && n < 16) begin
                if (b == 8'h7D) begin
                    esc = 1'b1;
                end else begin
                    rx_buf[n] = esc ? (b ^ 8'h20) : b;
                    n++;
                    esc = 1'b0;
                end
            end
        end
    end
endmodule

// ==== tb/logger_mode_status_framer_tb.sv ====
`timescale 1ns/10ps
module logger_mode_status_framer_tb;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic usb_host_in, upgrade_btn_in, cfg_done_in, cfg_valid_in, dflt_written_in;
    logic autobaud_in, rate_found_in, bus_act_in, mem_wr_in, mem_err_in, upload_done_in;
    logic pl_valid_in, pl_last_in, msg_tx_in;
    logic [7:0] pl_data_in;
    logic pl_ready_out, usb_storage_mode_out, fw_accept_out, img_armed_out, serial_en_out;
    logic cfg_read_out, cfg_load_out, dflt_write_out, tx_out;
    logic led_green_out, led_yellow_out, led_red_out;
    logic y_q = 1'b0;
    logic r_q = 1'b0;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int y_rises, r_rises, loads, dwrs, frames, hlen;
    logic hgood;
    logic [7:0] hdata [8];

    always #10 core_clk_in = ~core_clk_in;

    lmf_framer_top #(.FLASH_CYC(24'h000008), .ACT_CYC(24'h000004)) lmf_framer_top_i (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .usb_host_in(usb_host_in),
        .upgrade_btn_in(upgrade_btn_in), .cfg_done_in(cfg_done_in), .cfg_valid_in(cfg_valid_in),
        .dflt_written_in(dflt_written_in), .autobaud_in(autobaud_in),
        .rate_found_in(rate_found_in), .bus_act_in(bus_act_in), .mem_wr_in(mem_wr_in),
        .mem_err_in(mem_err_in), .upload_done_in(upload_done_in), .pl_valid_in(pl_valid_in),
        .pl_data_in(pl_data_in), .pl_last_in(pl_last_in), .msg_tx_in(msg_tx_in),
        .pl_ready_out(pl_ready_out), .usb_storage_mode_out(usb_storage_mode_out),
        .fw_accept_out(fw_accept_out), .img_armed_out(img_armed_out),
        .serial_en_out(serial_en_out), .cfg_read_out(cfg_read_out),
        .cfg_load_out(cfg_load_out), .dflt_write_out(dflt_write_out),
        .led_green_out(led_green_out), .led_yellow_out(led_yellow_out),
        .led_red_out(led_red_out), .tx_out(tx_out));

    lmf_host_model lmf_host_model_i (.core_clk_in(core_clk_in), .rx_in(tx_out),
        .frames_out(frames), .len_out(hlen), .good_out(hgood), .data_out(hdata));

    // ----------------------------------------
    // Event counters and hang guard
    // ----------------------------------------
    always @(posedge core_clk_in) begin
        y_q <= led_yellow_out;
        r_q <= led_red_out;
        if (led_yellow_out === 1'b1 && y_q !== 1'b1) y_rises++;
        if (led_red_out === 1'b1 && r_q !== 1'b1) r_rises++;
        if (cfg_load_out === 1'b1) loads++;
        if (dflt_write_out === 1'b1) dwrs++;
        cyc++;
        if (cyc == 100000) begin
            fails++;
            conclude();
        end
    end

    task automatic chk(input logic c, input string m);
        cmp_count++;
        if (c !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    task automatic do_reset(input logic h, input logic b);
        reset_in = 1'b1;
        usb_host_in = h;
        upgrade_btn_in = b;
        {cfg_done_in, cfg_valid_in, dflt_written_in, autobaud_in, rate_found_in} = 5'h00;
        {bus_act_in, mem_wr_in, mem_err_in, upload_done_in} = 4'h0;
        {pl_valid_in, pl_last_in, msg_tx_in, pl_data_in} = 11'h000;
        tick(5);
        reset_in = 1'b0;
        tick(4);
        {y_rises, r_rises, loads, dwrs} = {32'h0, 32'h0, 32'h0, 32'h0};
    endtask

    task automatic send_frame(input logic sel, input logic [15:0] d, input int n);
        int f0;
        int w;
        f0 = frames;
        for (int k = 0; k < n; k++) begin
            pl_valid_in = 1'b1;
            pl_data_in = d[15 - 8 * k -: 8];
            pl_last_in = (k == n - 1);
            msg_tx_in = sel;
            w = 0;
            do begin
                @(posedge core_clk_in);
                w++;
            end while (pl_ready_out !== 1'b1 && w < 10000);
            #1;
        end
        pl_valid_in = 1'b0;
        pl_last_in = 1'b0;
        w = 0;
        while (frames == f0 && w < 30000) begin
            @(posedge core_clk_in);
            w++;
        end
        #1;
        chk(frames == f0 + 1, "frame not seen");
    endtask

    task automatic t_valid_cfg;
        do_reset(1'b0, 1'b0);
        chk(led_green_out === 1'b1 && led_yellow_out === 1'b0 && led_red_out === 1'b0, "boot");
        chk(cfg_read_out === 1'b1, "no config read");
        chk(usb_storage_mode_out === 1'b0 && serial_en_out === 1'b0, "storage open");
        cfg_done_in = 1'b1;
        cfg_valid_in = 1'b1;
        tick(1);
        cfg_done_in = 1'b0;
        tick(80);
        chk(loads == 1 && dwrs == 0, "load count");
        chk(y_rises == 3 && r_rises == 0 && led_green_out === 1'b1, "yellow flashes");
        bus_act_in = 1'b1;
        tick(1);
        bus_act_in = 1'b0;
        tick(2);
        chk(led_yellow_out === 1'b1 && led_red_out === 1'b0, "traffic blink");
        tick(10);
        mem_wr_in = 1'b1;
        tick(1);
        mem_wr_in = 1'b0;
        tick(2);
        chk(led_red_out === 1'b1 && led_yellow_out === 1'b0, "write blink");
        tick(10);
        chk(led_red_out === 1'b0 && serial_en_out === 1'b0, "idle log");
        usb_host_in = 1'b1;
        tick(3);
        chk(serial_en_out === 1'b1 && usb_storage_mode_out === 1'b0, "serial off");
        $display("test valid_cfg done");
    endtask

    task automatic t_serial;
        send_frame(1'b1, 16'h7E7D, 2);
        chk(hgood === 1'b1 && hlen == 3, "frame one check");
        chk(hdata[0] === 8'h02 && hdata[1] === 8'h7E && hdata[2] === 8'h7D, "frame one");
        send_frame(1'b0, 16'h5500, 1);
        chk(hgood === 1'b1 && hlen == 2 && hdata[0] === 8'h01 && hdata[1] === 8'h55, "id");
        mem_err_in = 1'b1;
        tick(3);
        chk(led_green_out === 1'b0 && led_yellow_out === 1'b1 && led_red_out === 1'b1, "err");
        mem_err_in = 1'b0;
        $display("test serial done");
    endtask

    task automatic t_default_cfg;
        do_reset(1'b0, 1'b0);
        cfg_done_in = 1'b1;
        autobaud_in = 1'b1;
        tick(1);
        cfg_done_in = 1'b0;
        tick(10);
        chk(dwrs == 1 && loads == 0, "default write");
        dflt_written_in = 1'b1;
        tick(1);
        dflt_written_in = 1'b0;
        tick(80);
        chk(loads == 1 && r_rises == 3, "red flashes");
        chk(led_yellow_out === 1'b1 && led_green_out === 1'b1 && y_rises == 1, "rate wait");
        rate_found_in = 1'b1;
        tick(3);
        chk(led_yellow_out === 1'b0 && led_green_out === 1'b1, "rate found");
        $display("test default_cfg done");
    endtask

    task automatic t_upgrade;
        do_reset(1'b1, 1'b1);
        chk(led_red_out === 1'b1 && led_green_out === 1'b0 && led_yellow_out === 1'b0, "upg");
        chk(fw_accept_out === 1'b1 && img_armed_out === 1'b0, "upgrade accept");
        upload_done_in = 1'b1;
        tick(20);
        chk(img_armed_out === 1'b1 && fw_accept_out === 1'b0, "image armed");
        do_reset(1'b1, 1'b0);
        chk(img_armed_out === 1'b0 && usb_storage_mode_out === 1'b1, "storage mode");
        chk(fw_accept_out === 1'b0 && serial_en_out === 1'b0, "storage accepts");
        $display("test upgrade done");
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        t_valid_cfg();
        t_serial();
        t_default_cfg();
        t_upgrade();
        conclude();
    end
endmodule
